// [design/sfep_core.sv]
`timescale 1ns/1ps
`include "sfep_map.svh"
// Overview of operation
// [R1] opcode 20 wipes the whole addressed 4 KB sector to ones
// [R2] opcode D8 wipes the whole addressed 64 KB block to ones
// [R3] opcode 52 wipes the whole addressed 32 KB block to ones
// [R4] opcode 60 or C7 wipes the entire array to ones
// [R5] host sets the write unlock latch before any wipe or write
// [R6] any address inside a region selects the whole region
// [R7] address wipes need chip select rising right after last address bit
// [R8] array wipe is opcode only, chip select rising on a byte boundary
// [R9] host sends three address bytes after the opcode
// [R10] opcodes taken over eight serial clocks or two four-line clocks
// [R11] single-line mode ignores data lines one to three
// [R12] cycle starts at chip select rise; busy held; end clears busy, latch
// [R13] protected target leaves array unchanged but clears the latch
// [R14] any protection blocks array wipe but still clears the latch
// [R15] page write only clears bits; last 256 bytes kept
// [R16] data past page end wraps to offset zero of same page
// [R17] up to 256 bytes programmed at their addresses, rest untouched
// [R18] host sends at least one data byte in a page write
// [R19] page write needs chip select rising after a whole data byte
// [R20] host sets quad lines enable before quad page write
// [R21] quad page write carries address and data four bits per clock
// [R22] host may slow the clock below 104 MHz for quad data
// [R23] quad lines enable gates four-line data transfer
// [R24] commands with the latch clear are ignored
// [R25] while busy, wipe and write commands are rejected; status still read
module sfep_core #(
  parameter int SECTOR_CYC = `SFEP_US_TO_CYC(`SFEP_SECTOR_WIPE_TIME_US),
  parameter int MID_CYC = `SFEP_US_TO_CYC(`SFEP_HALF_BLOCK_WIPE_TIME_US),
  parameter int LARGE_CYC = `SFEP_US_TO_CYC(`SFEP_BLOCK_WIPE_TIME_US),
  parameter int ARRAY_CYC = `SFEP_US_TO_CYC(`SFEP_ARRAY_WIPE_TIME_US),
  parameter int PAGE_CYC = `SFEP_US_TO_CYC(`SFEP_PAGE_WRITE_TIME_US)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic [3:0] data_line_in,
  output logic [3:0] data_line_out,
  output logic [3:0] data_line_oe_b,
  input wire sfep_pkg::sfep_cfg_t cfg,
  input wire logic region_locked,
  input wire logic any_locked,
  output logic busy_flag,
  output logic write_unlock_latch,
  output sfep_pkg::sfep_mem_req_t mem_req,
  output logic mem_req_valid
);
  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic [5:0] pins_s;
  sfep_link_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_in({cs_b, sclk, data_line_in}),
    .pin_out(pins_s)
  );
  logic cs_s;
  logic sclk_s;
  logic [3:0] dl_s;
  assign cs_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign dl_s = pins_s[3:0];

  logic sclk_d_ff;
  logic cs_d_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_ff & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d_ff & ~cs_s;
  assign cs_rise = cs_s & ~cs_d_ff;
  assign cs_fall = ~cs_s & cs_d_ff;

  // ----------------------------------------
  // bit shifter and byte framing
  // ----------------------------------------
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DATA,
    PH_STATUS,
    PH_IGNORE
  } sfep_phase_t;

  sfep_phase_t phase_ff;
  logic [7:0] shift_ff;
  logic [3:0] bitcnt_ff;
  logic [1:0] addr_bytes_ff;
  logic [7:0] opcode_ff;
  logic [23:0] addr_ff;
  logic [8:0] data_cnt_ff;
  logic wide_ff;
  logic [7:0] stat_sh_ff;
  logic wide_now;
  logic [7:0] nxt_shift;
  logic [3:0] nxt_bitcnt;
  logic byte_done;
  logic [3:0] step;

  // [R10] [R21] four lines in command mode, or for quad write after opcode
  assign wide_now = (phase_ff == PH_OPCODE) ? cfg.four_line_command_mode : wide_ff;
  assign step = wide_now ? 4'h4 : 4'h1;
  always_comb begin
    if (wide_now) begin
      nxt_shift = {shift_ff[3:0], dl_s};
    end else begin
      nxt_shift = {shift_ff[6:0], dl_s[0]}; // [R11]
    end
    nxt_bitcnt = bitcnt_ff + step;
  end
  assign byte_done = sclk_rise && (nxt_bitcnt == 4'h8);

  logic is_erase_addr;
  logic is_array;
  logic is_page;
  logic is_quad;
  always_comb begin
    is_erase_addr = (nxt_shift == `SFEP_OP_FOUR_KB_WIPE) ||
      (nxt_shift == `SFEP_OP_MID_BLOCK_WIPE) || (nxt_shift == `SFEP_OP_LARGE_BLOCK_WIPE);
    is_array = (nxt_shift == `SFEP_OP_ARRAY_WIPE_A) || (nxt_shift == `SFEP_OP_ARRAY_WIPE_B);
    is_quad = (nxt_shift == `SFEP_OP_QUAD_PAGE_WRITE);
    is_page = (nxt_shift == `SFEP_OP_PAGE_WRITE) || is_quad;
  end

  // ----------------------------------------
  // page buffer
  // ----------------------------------------
  logic [7:0] page_buf [0:255];
  logic [255:0] page_hit_ff;
  logic [7:0] wr_ptr_ff;

  always_ff @(posedge ref_clk) begin
    if (byte_done && phase_ff == PH_DATA) begin
      page_buf[wr_ptr_ff] <= nxt_shift;
    end
  end

  logic job_go;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      page_hit_ff <= '0;
      wr_ptr_ff <= 8'h00;
    end else if (cs_fall) begin
      page_hit_ff <= '0;
    end else if (phase_ff == PH_ADDR && byte_done && addr_bytes_ff == 2'd2) begin
      wr_ptr_ff <= nxt_shift;
    end else if (byte_done && phase_ff == PH_DATA) begin
      page_hit_ff[wr_ptr_ff] <= 1'b1; // [R15] [R17]
      wr_ptr_ff <= wr_ptr_ff + 8'h01; // [R16]
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_ff <= PH_OPCODE;
      shift_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
      addr_bytes_ff <= 2'd0;
      opcode_ff <= 8'h00;
      addr_ff <= 24'h00_0000;
      data_cnt_ff <= 9'h000;
      wide_ff <= 1'b0;
    end else if (cs_fall || cs_s) begin
      phase_ff <= PH_OPCODE;
      bitcnt_ff <= 4'h0;
      addr_bytes_ff <= 2'd0;
      if (cs_fall) begin
        data_cnt_ff <= 9'h000;
        opcode_ff <= 8'h00;
        wide_ff <= 1'b0;
      end
    end else if (sclk_rise) begin
      shift_ff <= nxt_shift;
      bitcnt_ff <= byte_done ? 4'h0 : nxt_bitcnt;
      if (byte_done) begin
        case (phase_ff)
          PH_OPCODE: begin
            opcode_ff <= nxt_shift;
            if (nxt_shift == `SFEP_OP_STATUS_READ) begin
              phase_ff <= PH_STATUS;
            end else if (is_erase_addr || is_page) begin
              phase_ff <= PH_ADDR; // [R9]
              // [R23] quad path only when enabled
              wide_ff <= cfg.four_line_command_mode | (is_quad & cfg.quad_lines_enable);
            end else begin
              phase_ff <= PH_IGNORE;
            end
          end
          PH_ADDR: begin
            addr_ff <= {addr_ff[15:0], nxt_shift};
            addr_bytes_ff <= addr_bytes_ff + 2'd1;
            if (addr_bytes_ff == 2'd2) begin
              phase_ff <= (opcode_ff == `SFEP_OP_PAGE_WRITE ||
                opcode_ff == `SFEP_OP_QUAD_PAGE_WRITE) ? PH_DATA : PH_IGNORE;
            end
          end
          PH_DATA: begin
            if (data_cnt_ff != 9'h1ff) begin
              data_cnt_ff <= data_cnt_ff + 9'h001;
            end
          end
          PH_STATUS: begin
            phase_ff <= PH_STATUS;
          end
          PH_IGNORE: begin
            phase_ff <= PH_IGNORE;
            opcode_ff <= 8'h00; // [R7] [R8]
          end
          default: begin
            phase_ff <= PH_IGNORE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // job qualification at chip select rise
  // ----------------------------------------
  logic on_boundary;
  logic addr_done;
  logic quad_ok;
  sfep_pkg::sfep_job_t nxt_job;
  assign on_boundary = (bitcnt_ff == 4'h0);
  assign addr_done = (addr_bytes_ff == 2'd3);
  assign quad_ok = (opcode_ff != `SFEP_OP_QUAD_PAGE_WRITE) || cfg.quad_lines_enable;
  always_comb begin
    nxt_job = sfep_pkg::SFEP_JOB_NONE;
    if (phase_ff == PH_IGNORE && on_boundary && addr_done) begin // [R7]
      case (opcode_ff)
        `SFEP_OP_FOUR_KB_WIPE: nxt_job = sfep_pkg::SFEP_JOB_SECTOR;
        `SFEP_OP_MID_BLOCK_WIPE: nxt_job = sfep_pkg::SFEP_JOB_MID;
        `SFEP_OP_LARGE_BLOCK_WIPE: nxt_job = sfep_pkg::SFEP_JOB_LARGE;
        default: nxt_job = sfep_pkg::SFEP_JOB_NONE;
      endcase
    end else if (phase_ff == PH_IGNORE && on_boundary && addr_bytes_ff == 2'd0 &&
      (opcode_ff == `SFEP_OP_ARRAY_WIPE_A || opcode_ff == `SFEP_OP_ARRAY_WIPE_B)) begin
      nxt_job = sfep_pkg::SFEP_JOB_ARRAY; // [R8]
    end else if (phase_ff == PH_DATA && on_boundary && data_cnt_ff != 9'h000 && quad_ok) begin
      nxt_job = sfep_pkg::SFEP_JOB_PAGE; // [R19]
    end
  end
  // [R24] [R25] latch set and idle required
  assign job_go = cs_rise && (nxt_job != sfep_pkg::SFEP_JOB_NONE) &&
    write_unlock_latch && !busy_flag;

  // ----------------------------------------
  // self-timed cycle
  // ----------------------------------------
  sfep_pkg::sfep_job_t job_ff;
  logic [31:0] timer_ff;
  logic blocked_ff;
  logic [8:0] emit_ff;
  logic [23:0] page_base_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      job_ff <= sfep_pkg::SFEP_JOB_NONE;
      timer_ff <= 32'h0000_0000;
      blocked_ff <= 1'b0;
      busy_flag <= 1'b0;
      page_base_ff <= 24'h00_0000;
    end else if (job_go) begin
      job_ff <= nxt_job;
      busy_flag <= 1'b1; // [R12]
      page_base_ff <= addr_ff & `SFEP_PAGE_MASK;
      // [R13] [R14]
      blocked_ff <= (nxt_job == sfep_pkg::SFEP_JOB_ARRAY) ? any_locked : region_locked;
      case (nxt_job)
        sfep_pkg::SFEP_JOB_SECTOR: timer_ff <= 32'(SECTOR_CYC);
        sfep_pkg::SFEP_JOB_MID: timer_ff <= 32'(MID_CYC);
        sfep_pkg::SFEP_JOB_LARGE: timer_ff <= 32'(LARGE_CYC);
        sfep_pkg::SFEP_JOB_ARRAY: timer_ff <= 32'(ARRAY_CYC);
        default: timer_ff <= 32'(PAGE_CYC);
      endcase
    end else if (busy_flag) begin
      if (timer_ff <= 32'h0000_0001) begin
        busy_flag <= 1'b0; // [R12]
        job_ff <= sfep_pkg::SFEP_JOB_NONE;
      end else begin
        timer_ff <= timer_ff - 32'h0000_0001;
      end
    end
  end

  // page bytes emitted one per cycle at cycle start; a wipe emits a single request
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      emit_ff <= 9'h000;
      mem_req <= '0;
      mem_req_valid <= 1'b0;
    end else begin
      mem_req_valid <= 1'b0;
      mem_req <= '0;
      if (job_go) begin
        emit_ff <= (nxt_job == sfep_pkg::SFEP_JOB_PAGE) ? 9'h100 : 9'h001;
      end else if (emit_ff != 9'h000 && !blocked_ff) begin
        emit_ff <= emit_ff - 9'h001;
        mem_req_valid <= 1'b1;
        case (job_ff)
          sfep_pkg::SFEP_JOB_SECTOR: begin
            mem_req.wipe <= 1'b1;
            mem_req.base <= addr_ff & `SFEP_SECTOR_MASK; // [R1] [R6]
            mem_req.mask <= ~`SFEP_SECTOR_MASK;
          end
          sfep_pkg::SFEP_JOB_MID: begin
            mem_req.wipe <= 1'b1;
            mem_req.base <= addr_ff & `SFEP_MID_MASK; // [R3] [R6]
            mem_req.mask <= ~`SFEP_MID_MASK;
          end
          sfep_pkg::SFEP_JOB_LARGE: begin
            mem_req.wipe <= 1'b1;
            mem_req.base <= addr_ff & `SFEP_LARGE_MASK; // [R2] [R6]
            mem_req.mask <= ~`SFEP_LARGE_MASK;
          end
          sfep_pkg::SFEP_JOB_ARRAY: begin
            mem_req.wipe <= 1'b1;
            mem_req.base <= 24'h00_0000; // [R4]
            mem_req.mask <= 24'hff_ffff;
          end
          default: begin
            // [R15] [R17] only touched offsets, program clears bits only
            mem_req_valid <= page_hit_ff[8'(9'h100 - emit_ff)];
            mem_req.write <= 1'b1;
            mem_req.base <= page_base_ff | {16'h0000, 8'(9'h100 - emit_ff)};
            mem_req.mask <= 24'h00_0000;
            mem_req.data <= page_buf[8'(9'h100 - emit_ff)];
          end
        endcase
      end else if (emit_ff != 9'h000) begin
        emit_ff <= 9'h000;
      end
    end
  end

  // ----------------------------------------
  // write unlock latch
  // ----------------------------------------
  logic unlock_seen;
  assign unlock_seen = cs_rise && opcode_ff == `SFEP_OP_WRITE_UNLOCK && on_boundary &&
    phase_ff == PH_IGNORE && !busy_flag;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      write_unlock_latch <= 1'b0;
    end else if (unlock_seen) begin
      write_unlock_latch <= 1'b1; // [R5]
    end else if (busy_flag && timer_ff <= 32'h0000_0001) begin
      write_unlock_latch <= 1'b0; // [R12] [R13] [R14]
    end
  end

  // ----------------------------------------
  // status read out, shifted on falling clock
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stat_sh_ff <= 8'h00;
    end else if (phase_ff != PH_STATUS) begin
      stat_sh_ff <= {6'h00, write_unlock_latch, busy_flag}; // [R25]
    end else if (sclk_fall) begin
      stat_sh_ff <= {stat_sh_ff[6:0], stat_sh_ff[7]};
    end
  end
  assign data_line_out = {2'b00, stat_sh_ff[7], 1'b0};
  assign data_line_oe_b = (phase_ff == PH_STATUS && !cs_s) ? 4'b1101 : 4'b1111;
endmodule : sfep_core

// [design/sfep_link_sync.sv]
`timescale 1ns/1ps
`include "sfep_map.svh"
// ----------------------------------------
// three-stage sampler, change taken when stages 2 and 3 agree
// ----------------------------------------
module sfep_link_sync (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out
);
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic q_ff;
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          s1_ff <= 1'b1;
          s2_ff <= 1'b1;
          s3_ff <= 1'b1;
          q_ff <= 1'b1;
        end else begin
          s1_ff <= pin_in[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            q_ff <= s3_ff;
          end
        end
      end
      assign pin_out[gi] = q_ff;
    end
  endgenerate
endmodule : sfep_link_sync

// [design/sfep_map.svh]
`ifndef SFEP_MAP_SVH
`define SFEP_MAP_SVH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFEP_OP_FOUR_KB_WIPE 8'h20
`define SFEP_OP_MID_BLOCK_WIPE 8'h52
`define SFEP_OP_LARGE_BLOCK_WIPE 8'hd8
`define SFEP_OP_ARRAY_WIPE_A 8'h60
`define SFEP_OP_ARRAY_WIPE_B 8'hc7
`define SFEP_OP_PAGE_WRITE 8'h02
`define SFEP_OP_QUAD_PAGE_WRITE 8'h38
`define SFEP_OP_WRITE_UNLOCK 8'h06
`define SFEP_OP_STATUS_READ 8'h05
// ----------------------------------------
// geometry
// ----------------------------------------
`define SFEP_ADDR_W 24
`define SFEP_PAGE_BYTES 256
`define SFEP_SECTOR_MASK 24'hff_f000
`define SFEP_MID_MASK 24'hff_8000
`define SFEP_LARGE_MASK 24'hff_0000
`define SFEP_PAGE_MASK 24'hff_ff00
// ----------------------------------------
// timing
// ----------------------------------------
`define SFEP_CLK_PERIOD_NS 4
`define SFEP_SECTOR_WIPE_TIME_US 30
`define SFEP_HALF_BLOCK_WIPE_TIME_US 150
`define SFEP_BLOCK_WIPE_TIME_US 300
`define SFEP_ARRAY_WIPE_TIME_US 3000
`define SFEP_PAGE_WRITE_TIME_US 10
`define SFEP_US_TO_CYC(t) ((t) * 1000 / `SFEP_CLK_PERIOD_NS)
`endif

// [design/sfep_pkg.sv]
package sfep_pkg;
  typedef enum logic [2:0] {
    SFEP_JOB_NONE,
    SFEP_JOB_SECTOR,
    SFEP_JOB_MID,
    SFEP_JOB_LARGE,
    SFEP_JOB_ARRAY,
    SFEP_JOB_PAGE
  } sfep_job_t;

  // array-side request to the storage
  typedef struct packed {
    logic wipe;
    logic write;
    logic [23:0] base;
    logic [23:0] mask;
    logic [7:0] data;
  } sfep_mem_req_t;

  // protection and line mode settings from the status register
  typedef struct packed {
    logic protect_scheme_select;
    logic [3:0] block_protect_bits;
    logic quad_lines_enable;
    logic four_line_command_mode;
  } sfep_cfg_t;
endpackage : sfep_pkg

// [testbench/sfep_core_properties.sv]
`timescale 1ns/1ps
module sfep_core_properties #(
  parameter int SECTOR_CYC = 40,
  parameter int MID_CYC = 50,
  parameter int LARGE_CYC = 60,
  parameter int ARRAY_CYC = 70,
  parameter int PAGE_CYC = 300
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic region_locked,
  input wire logic any_locked,
  input wire logic busy_flag,
  input wire logic write_unlock_latch,
  input wire sfep_pkg::sfep_mem_req_t mem_req,
  input wire logic mem_req_valid
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_rise;
    !busy_flag ##1 busy_flag;
  endsequence
  sequence s_hold;
    busy_flag [*8];
  endsequence
  a_busy_holds: assert property (s_rise |=> s_hold)
    else $error("busy dropped early");
  a_start_at_cs: assert property ($rose(busy_flag) |-> cs_b)
    else $error("busy rose while selected");
  a_start_latch: assert property ($rose(busy_flag) |-> $past(write_unlock_latch))
    else $error("cycle started without latch");
  a_end_clears: assert property ($fell(busy_flag) |-> !write_unlock_latch)
    else $error("latch kept after cycle");
  a_no_relatch: assert property (busy_flag && $past(busy_flag) |-> !$rose(write_unlock_latch))
    else $error("latch set while busy");
  a_req_in_busy: assert property (mem_req_valid |-> busy_flag)
    else $error("request outside cycle");
  a_wipe_aligned: assert property (mem_req_valid && mem_req.wipe |->
    (mem_req.base & mem_req.mask) == 24'h00_0000)
    else $error("wipe base not aligned");
  a_wipe_region: assert property (mem_req_valid && mem_req.wipe |-> mem_req.mask inside
    {24'h00_0fff, 24'h00_7fff, 24'h00_ffff, 24'hff_ffff})
    else $error("wipe size wrong");
  a_protect_none: assert property (mem_req_valid |-> !region_locked)
    else $error("protected region touched");
  a_array_guard: assert property (mem_req_valid && mem_req.mask == 24'hff_ffff |-> !any_locked)
    else $error("array wiped while locked");
  a_write_only: assert property (mem_req_valid && mem_req.write |-> !mem_req.wipe)
    else $error("write mixed with wipe");
endmodule : sfep_core_properties

bind sfep_core sfep_core_properties #(.SECTOR_CYC(SECTOR_CYC), .MID_CYC(MID_CYC),
  .LARGE_CYC(LARGE_CYC), .ARRAY_CYC(ARRAY_CYC), .PAGE_CYC(PAGE_CYC)) i_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .region_locked(region_locked),
  .any_locked(any_locked), .busy_flag(busy_flag), .write_unlock_latch(write_unlock_latch),
  .mem_req(mem_req), .mem_req_valid(mem_req_valid));

// [testbench/sfep_host.sv]
`timescale 1ns/1ps
module sfep_host (
  output logic cs_b,
  output logic sclk,
  output logic [3:0] dl
);
  logic [7:0] buf_q [$];
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    dl = 4'h0;
  end
  // 160 ns serial clock, well under 104 MHz
  task automatic put(input logic [3:0] v);
    dl = v;
    #80 sclk = 1'b1;
    #80 sclk = 1'b0;
  endtask : put
  // bytes from qfrom on go four bits per clock; stray bits follow
  task automatic xfer(input int qfrom, input int xbits);
    cs_b = 1'b0;
    #80;
    foreach (buf_q[i]) begin
      if (i >= qfrom) begin
        put(buf_q[i][7:4]);
        put(buf_q[i][3:0]);
      end else begin
        for (int k = 7; k >= 0; k--) put({~dl[3:1], buf_q[i][k]});
      end
    end
    repeat (xbits) put({~dl[3:1], 1'b1});
    #80 cs_b = 1'b1;
    dl = ~dl;
    buf_q.delete();
    #400;
  endtask : xfer
endmodule : sfep_host

// [testbench/tb_sfep_core.sv]
`timescale 1ns/1ps
module tb_sfep_core;
  logic ref_clk, rst_b, region_locked, any_locked, cs_b, sclk;
  logic [3:0] hd, din, dout, oe_b;
  sfep_pkg::sfep_cfg_t cfg;
  sfep_pkg::sfep_mem_req_t mem_req, last_q;
  logic mem_req_valid, busy_flag, write_unlock_latch;
  logic [7:0] pg [256];
  int bad_count, checked, blen, run_c, nreq, cmd_q, st_seen;
  assign din = {hd[3:2], oe_b[1] ? hd[1] : dout[1], hd[0]};
  sfep_host i_host (.cs_b(cs_b), .sclk(sclk), .dl(hd));
  sfep_core #(.SECTOR_CYC(40), .MID_CYC(50), .LARGE_CYC(60), .ARRAY_CYC(3000),
    .PAGE_CYC(300)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
    .data_line_in(din), .data_line_out(dout), .data_line_oe_b(oe_b), .cfg(cfg),
    .region_locked(region_locked), .any_locked(any_locked), .busy_flag(busy_flag),
    .write_unlock_latch(write_unlock_latch), .mem_req(mem_req), .mem_req_valid(mem_req_valid));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // monitor of requests and busy spans
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (mem_req_valid === 1'b1) begin
      nreq <= nreq + 1;
      last_q <= mem_req;
      if (mem_req.write === 1'b1) pg[mem_req.base[7:0]] <= mem_req.data;
    end
    if (oe_b == 4'b1101 && dout[1] === 1'b1) st_seen <= 1;
    if (busy_flag === 1'b1) run_c <= run_c + 1;
    else if (run_c != 0) begin
      blen <= run_c;
      run_c <= 0;
    end
  end
  function automatic logic [7:0] dat(input int j);
    logic [31:0] v;
    v = j;
    return v[8:1] ^ 8'h3c;
  endfunction : dat
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic send(input logic [7:0] op, input int na, input logic [23:0] a,
    input int nd, input int qf, input int xb);
    @(posedge ref_clk);
    #1;
    i_host.buf_q.push_back(op);
    for (int j = 0; j < na; j++) i_host.buf_q.push_back(a[23 - 8 * j -: 8]);
    for (int j = 0; j < nd; j++) i_host.buf_q.push_back(dat(j));
    i_host.xfer(qf, xb);
  endtask : send
  task automatic run(input logic [7:0] op, input int na, input logic [23:0] a,
    input int nd, input int qf, input int xb);
    send(8'h06, 0, 24'h00_0000, 0, cmd_q, 0);
    blen = 0;
    nreq = 0;
    send(op, na, a, nd, qf, xb);
    for (int n = 0; n < 5000 && busy_flag !== 1'b0; n++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask : run
  task automatic t_wipes();
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
    logic [23:0] msk [5] = '{24'h00_0fff, 24'h00_7fff, 24'h00_ffff, 24'hff_ffff, 24'hff_ffff};
    int cyc [5] = '{40, 50, 60, 3000, 3000};
    for (int i = 0; i < 5; i++) begin
      run(ops[i], (i < 3) ? 3 : 0, 24'h12_3456, 0, 99, 0);
      chk("wipe mask", msk[i], last_q.mask);
      chk("wipe base", 24'h12_3456 & ~msk[i], last_q.base);
      chk("busy span", 1, blen >= cyc[i] - 1 && blen <= cyc[i] + 1);
      chk("latch after", 0, write_unlock_latch);
    end
    cfg.four_line_command_mode = 1'b1;
    cmd_q = 0;
    run(8'h20, 3, 24'h00_5abc, 0, 0, 0);
    chk("four line base", 24'h00_5000, last_q.base);
    cfg.four_line_command_mode = 1'b0;
    cmd_q = 99;
    $display("wipes done");
  endtask : t_wipes
  task automatic t_refuse();
    blen = 0;
    send(8'h20, 3, 24'h00_1000, 0, 99, 0);
    repeat (60) @(posedge ref_clk);
    chk("locked out busy", 0, blen);
    run(8'h20, 3, 24'h00_1000, 0, 99, 4);
    chk("stray bits busy", 0, blen);
    run(8'h20, 3, 24'h00_1000, 0, 99, 8);
    chk("extra byte busy", 0, blen);
    chk("latch kept", 1, write_unlock_latch);
    run(8'hc7, 0, 24'h00_0000, 0, 99, 3);
    chk("array stray busy", 0, blen);
    run(8'h02, 3, 24'h00_2000, 1, 99, 5);
    chk("part byte busy", 0, blen);
    run(8'h38, 3, 24'h00_2000, 4, 1, 0);
    chk("quad gated", 0, blen);
    $display("refusals done");
  endtask : t_refuse
  task automatic t_protect();
    region_locked = 1'b1;
    run(8'hd8, 3, 24'h34_0000, 0, 99, 0);
    chk("locked req", 0, nreq);
    chk("locked busy", 1, blen > 0);
    chk("locked latch", 0, write_unlock_latch);
    region_locked = 1'b0;
    any_locked = 1'b1;
    run(8'h60, 0, 24'h00_0000, 0, 99, 0);
    chk("array req", 0, nreq);
    chk("array latch", 0, write_unlock_latch);
    any_locked = 1'b0;
    $display("protection done");
  endtask : t_protect
  task automatic t_busy();
    nreq = 0;
    send(8'h06, 0, 24'h00_0000, 0, 99, 0);
    send(8'h60, 0, 24'h00_0000, 0, 99, 0);
    st_seen = 0;
    send(8'h05, 0, 24'h00_0000, 0, 99, 8);
    chk("status busy", 1, st_seen);
    send(8'h06, 0, 24'h00_0000, 0, 99, 0);
    send(8'h20, 3, 24'h00_1000, 0, 99, 0);
    for (int n = 0; n < 5000 && busy_flag !== 1'b0; n++) @(posedge ref_clk);
    repeat (200) @(posedge ref_clk);
    chk("busy reqs", 1, nreq);
    chk("busy after", 0, busy_flag);
    chk("busy latch", 0, write_unlock_latch);
    $display("busy refusal done");
  endtask : t_busy
  task automatic t_page();
    logic [7:0] o;
    run(8'h02, 3, 24'h01_00f0, 20, 99, 0);
    chk("page reqs", 20, nreq);
    chk("page base", 24'h01_0000, last_q.base & 24'hff_ff00);
    for (int j = 0; j < 20; j++) begin
      o = 8'hf0 + j[7:0];
      chk("page byte", dat(j), pg[o]);
    end
    cfg.quad_lines_enable = 1'b1;
    run(8'h38, 3, 24'h02_0000, 260, 1, 0);
    chk("quad reqs", 256, nreq);
    for (int j = 0; j < 8; j++) chk("quad byte", dat(j < 4 ? j + 256 : j), pg[j]);
    $display("page writes done");
  endtask : t_page
  task automatic finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #380_000;
    bad_count++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    cfg = '0;
    region_locked = 1'b0;
    any_locked = 1'b0;
    cmd_q = 99;
    repeat (5) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("reset busy", 0, busy_flag);
    chk("reset latch", 0, write_unlock_latch);
    chk("reset oe", 4'b1111, oe_b);
    t_wipes();
    t_refuse();
    t_protect();
    t_busy();
    t_page();
    finish_test();
  end
endmodule : tb_sfep_core
